/* pcie_stream_to_sdram_bridge.sv */
// bridge between a 64-bit packet stream port and an sdram local request port
`timescale 1ns/10ps
// Contract
// - Raise rx_nonposted_hold while a read cannot be taken.
// - All outgoing packets leave on the 64-bit tx_packet_word bus.
// - tx_word_valid is high exactly when tx_packet_word holds packet data.
// - tx_first_word pulses once with the first word of each packet.
// - tx_last_word pulses once with the final word of each packet.
// - Maximum read request size comes from the 32-bit control status input.
// - Completer id comes from the 13-bit bus/device input; requester id and tag come from the read request header.
// - Request address appears on the 25-bit mem_address output.
// - mem_write_req asks for a write at mem_address.
// - mem_read_req asks for a read from mem_address.
// - After mem_wdata_req, the next write word follows one cycle later.
// - 128-bit write bus, only the low 64 bits carry data.
// - Per-byte mask qualifies each write word.
// - Burst length is given in plain binary on mem_burst_count.
// - Receive half issues requests and write data; tx half takes read data.
// - Everything runs on the single system clock.
// - Reset holds all logic in its idle state.
// - rx_app_accepting is high only while packet words can be taken.
module pcie_stream_to_sdram_bridge #(
   parameter int DEPTH = bridge_pkg::FIFO_DEPTH
) (
   input  wire logic                                clk_sys,
   input  wire logic                                srst,
   input  wire logic [bridge_pkg::STREAM_W-1:0]     rx_packet_data,
   input  wire logic                                rx_data_valid,
   input  wire logic                                rx_first_word,
   input  wire logic                                rx_last_word,
   output logic                                     rx_app_accepting,
   output logic                                     rx_nonposted_hold,
   output logic [bridge_pkg::STREAM_W-1:0]          tx_packet_word,
   output logic                                     tx_word_valid,
   output logic                                     tx_first_word,
   output logic                                     tx_last_word,
   input  wire logic                                tx_core_accepting,
   input  wire logic [bridge_pkg::CREDIT_W-1:0]     tx_credit_vector,
   input  wire logic [bridge_pkg::CSR_W-1:0]        device_ctrl_status_in,
   input  wire logic [bridge_pkg::BUSDEV_W-1:0]     bus_device_number_in,
   input  wire logic                                mem_ready,
   output logic [bridge_pkg::MEM_ADDR_W-1:0]        mem_address,
   output logic                                     mem_write_req,
   output logic                                     mem_read_req,
   input  wire logic                                mem_wdata_req,
   output logic [bridge_pkg::MEM_DATA_W-1:0]        mem_wdata,
   output logic [bridge_pkg::MEM_MASK_W-1:0]        mem_byte_mask,
   output logic [bridge_pkg::BURST_W-1:0]           mem_burst_count,
   input  wire logic [bridge_pkg::STREAM_W-1:0]     mem_rdata,
   input  wire logic                                mem_rdata_valid
);
   localparam int WW = bridge_pkg::STREAM_W + bridge_pkg::MASK_W;
   localparam int BW = bridge_pkg::BURST_W;
   localparam int LW = bridge_pkg::LEN_W;

   typedef enum logic [6:0] {
      RX_HDR0  = 7'h0_1,
      RX_HDR1  = 7'h0_2,
      RX_DATA  = 7'h0_4,
      RX_DROP  = 7'h0_8,
      MEM_WR   = 7'h1_0,
      MEM_RD   = 7'h2_0,
      MEM_WDAT = 7'h4_0
   } rx_state_e;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h1,
      TX_HDR1 = 3'h2,
      TX_DATA = 3'h4
   } tx_state_e;

   stream_if #(.W(WW)) wrIf ();
   stream_if #(.W(bridge_pkg::STREAM_W)) rdIf ();

   word_fifo #(.W(WW), .DEPTH(DEPTH)) u_wr_fifo (
      .clk_sys (clk_sys),
      .srst    (srst),
      .port    (wrIf.fifo_side)
   );
   word_fifo #(.W(bridge_pkg::STREAM_W), .DEPTH(DEPTH)) u_rd_fifo (
      .clk_sys (clk_sys),
      .srst    (srst),
      .port    (rdIf.fifo_side)
   );

   // ==========================================
   // helpers
   function automatic logic [BW-1:0] qwordBurst(input logic [LW-1:0] len, input logic [2:0] mrrs);
      logic [LW:0]   qw;
      logic [LW+1:0] lim;
      qw  = ({1'b0, len} + (LW+1)'(1)) >> 1;
      if (len == '0) qw = (LW+1)'(512);
      // one bit wider so the largest size code cannot wrap to zero
      lim = (LW+2)'(bridge_pkg::MRRS_MIN_QW) << mrrs;
      if ({1'b0, qw} > lim) qw = lim[LW:0];
      if (qw > (LW+1)'(DEPTH)) qw = (LW+1)'(DEPTH);
      qwordBurst = qw[BW-1:0];
   endfunction

   function automatic logic [7:0] wordMask(input logic [BW-1:0] idx, input logic [BW-1:0] last,
                                           input logic oddLen, input logic [3:0] fbe, input logic [3:0] lbe);
      logic [3:0] lo;
      logic [3:0] hi;
      lo = (idx == '0) ? fbe : 4'hF;
      hi = 4'hF;
      if (idx == last) begin
         if (oddLen) begin
            hi = 4'h0;
            if (idx != '0) lo = lbe;
         end else begin
            hi = lbe;
         end
      end
      wordMask = {hi, lo};
   endfunction

   // ==========================================
   // receive half: packet intake and memory requests
   rx_state_e rxState, next_rxState;
   logic [LW-1:0]  hdrLen, next_hdrLen;
   logic [3:0]     hdrFbe, next_hdrFbe, hdrLbe, next_hdrLbe;
   logic           hdrWrite, next_hdrWrite;
   logic [BW-1:0]  burst, next_burst, wordIdx, next_wordIdx;
   logic [BW-1:0]  wrSent, next_wrSent;
   logic [15:0]    reqId, next_reqId;
   logic [7:0]     reqTag, next_reqTag;
   logic [6:0]     lowAddr, next_lowAddr;
   logic [LW-1:0]  cplLen, next_cplLen;
   logic           readPending, next_readPending;
   logic           hdr4dw, next_hdr4dw;
   logic [bridge_pkg::MEM_ADDR_W-1:0] next_memAddress;
   logic [bridge_pkg::MEM_DATA_W-1:0] next_memWdata;
   logic [bridge_pkg::MEM_MASK_W-1:0] next_memMask;
   logic           rxTake, txDone;
   logic [31:0]    addrDw;
   logic [BW-1:0]  reqBurst;
   logic           isMem;

   assign rxTake   = rx_data_valid & rx_app_accepting;
   assign isMem    = (rx_packet_data[bridge_pkg::TYPE_LSB +: 5] == bridge_pkg::TYPE_MEM);
   assign addrDw   = hdr4dw ? rx_packet_data[63:32] : rx_packet_data[31:0];
   assign reqBurst = qwordBurst(hdrLen, device_ctrl_status_in[bridge_pkg::MRRS_LSB +: 3]);

   // write payload into the fifo, mask travels beside each word
   assign wrIf.inValid  = rxTake && (rxState == RX_DATA) && (wordIdx < burst);
   assign wrIf.inData   = {wordMask(wordIdx, burst - BW'(1), hdrLen[0], hdrFbe, hdrLbe), rx_packet_data};
   assign wrIf.outReady = mem_wdata_req && ((rxState == MEM_WR) || (rxState == MEM_WDAT)) && (wrSent < burst);

   always_comb begin
      next_rxState     = rxState;
      next_hdrLen      = hdrLen;
      next_hdrFbe      = hdrFbe;
      next_hdrLbe      = hdrLbe;
      next_hdrWrite    = hdrWrite;
      next_hdr4dw      = hdr4dw;
      next_burst       = burst;
      next_wordIdx     = wordIdx;
      next_wrSent      = wrSent;
      next_reqId       = reqId;
      next_reqTag      = reqTag;
      next_lowAddr     = lowAddr;
      next_cplLen      = cplLen;
      next_readPending = readPending & ~txDone;
      next_memAddress  = mem_address;
      next_memWdata    = mem_wdata;
      next_memMask     = mem_byte_mask;
      case (rxState)
         RX_HDR0: begin
            if (rxTake && rx_first_word) begin
               next_hdrLen   = rx_packet_data[LW-1:0];
               next_hdrWrite = rx_packet_data[bridge_pkg::FMT_DATA_BIT];
               next_hdr4dw   = rx_packet_data[bridge_pkg::FMT_4DW_BIT];
               next_hdrFbe   = rx_packet_data[bridge_pkg::FBE_LSB +: 4];
               next_hdrLbe   = rx_packet_data[bridge_pkg::LBE_LSB +: 4];
               // ids of a pending read stay put for its completion
               if (!rx_packet_data[bridge_pkg::FMT_DATA_BIT] && !readPending) begin
                  next_reqId  = rx_packet_data[bridge_pkg::REQID_LSB +: 16];
                  next_reqTag = rx_packet_data[bridge_pkg::TAG_LSB +: 8];
               end
               if (!isMem || (!rx_packet_data[bridge_pkg::FMT_DATA_BIT] && readPending)) begin
                  next_rxState = rx_last_word ? RX_HDR0 : RX_DROP;
               end else if (!rx_last_word) begin
                  next_rxState = RX_HDR1;
               end
            end
         end
         RX_HDR1: begin
            if (rxTake) begin
               next_memAddress = addrDw[bridge_pkg::ADDR_QW_LSB +: bridge_pkg::MEM_ADDR_W];
               next_burst      = reqBurst;
               next_wordIdx    = '0;
               next_wrSent     = '0;
               if (hdrWrite) begin
                  next_rxState = rx_last_word ? RX_HDR0 : RX_DATA;
               end else begin
                  next_cplLen  = (reqBurst == BW'(DEPTH)) ? LW'({reqBurst, 1'b0}) : hdrLen;
                  next_lowAddr = addrDw[6:0];
                  next_rxState = MEM_RD;
               end
            end
         end
         RX_DATA: begin
            if (rxTake) begin
               if (wordIdx < burst) next_wordIdx = wordIdx + BW'(1);
               if (rx_last_word) next_rxState = MEM_WR;
            end
         end
         RX_DROP: begin
            if (rxTake && rx_last_word) begin
               next_rxState = RX_HDR0;
            end
         end
         MEM_WR: begin
            if (mem_ready) next_rxState = MEM_WDAT;
         end
         MEM_RD: begin
            if (mem_ready) begin
               next_rxState     = RX_HDR0;
               next_readPending = 1'b1;
            end
         end
         MEM_WDAT: begin
            if (wrSent == burst) next_rxState = RX_HDR0;
         end
         default: next_rxState = RX_HDR0;
      endcase
      if (wrIf.outReady && wrIf.outValid) begin
         next_wrSent   = wrSent + BW'(1);
         next_memWdata = {64'h0000_0000_0000_0000, wrIf.outData[bridge_pkg::STREAM_W-1:0]};
         next_memMask  = {8'h00, wrIf.outData[WW-1 -: bridge_pkg::MASK_W]};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rxState           <= RX_HDR0;
         hdrLen            <= '0;
         hdrFbe            <= '0;
         hdrLbe            <= '0;
         hdrWrite          <= 1'b0;
         hdr4dw            <= 1'b0;
         burst             <= '0;
         wordIdx           <= '0;
         wrSent            <= '0;
         reqId             <= '0;
         reqTag            <= '0;
         lowAddr           <= '0;
         cplLen            <= '0;
         readPending       <= 1'b0;
         rx_app_accepting  <= 1'b0;
         rx_nonposted_hold <= 1'b0;
         mem_address       <= '0;
         mem_write_req     <= 1'b0;
         mem_read_req      <= 1'b0;
         mem_wdata         <= '0;
         mem_byte_mask     <= '0;
         mem_burst_count   <= '0;
      end else begin
         rxState           <= next_rxState;
         hdrLen            <= next_hdrLen;
         hdrFbe            <= next_hdrFbe;
         hdrLbe            <= next_hdrLbe;
         hdrWrite          <= next_hdrWrite;
         hdr4dw            <= next_hdr4dw;
         burst             <= next_burst;
         wordIdx           <= next_wordIdx;
         wrSent            <= next_wrSent;
         reqId             <= next_reqId;
         reqTag            <= next_reqTag;
         lowAddr           <= next_lowAddr;
         cplLen            <= next_cplLen;
         readPending       <= next_readPending;
         rx_app_accepting  <= (next_rxState == RX_HDR0) || (next_rxState == RX_HDR1)
                              || (next_rxState == RX_DATA) || (next_rxState == RX_DROP);
         rx_nonposted_hold <= next_readPending || (next_rxState == MEM_RD);
         mem_address       <= next_memAddress;
         mem_write_req     <= (next_rxState == MEM_WR);
         mem_read_req      <= (next_rxState == MEM_RD);
         mem_wdata         <= next_memWdata;
         mem_byte_mask     <= next_memMask;
         mem_burst_count   <= next_burst;
      end
   end

   // ==========================================
   // transmit half: read data becomes a completion
   tx_state_e txState, next_txState;
   logic [BW-1:0] rdCount, next_rdCount, txSent, next_txSent;
   logic [bridge_pkg::STREAM_W-1:0] next_txWord;
   logic          next_txValid, next_txFirst, next_txLast;
   logic          txAdvance;
   logic [BW-1:0] rdQw;
   logic [15:0]   completerId;
   logic [31:0]   cplH0, cplH1, cplH2;

   assign completerId   = {bus_device_number_in, bridge_pkg::FUNC_NUM};
   assign rdQw          = BW'((cplLen + LW'(1)) >> 1); // write headers may reload burst meanwhile
   assign cplH0         = {bridge_pkg::CPLD_BYTE0, 14'h0000, cplLen};
   assign cplH1         = {completerId, 4'h0, cplLen, 2'b00};
   assign cplH2         = {reqId, reqTag, 1'b0, lowAddr};
   assign txAdvance     = !tx_word_valid || tx_core_accepting;
   assign rdIf.inValid  = mem_rdata_valid && readPending;
   assign rdIf.inData   = mem_rdata;
   assign rdIf.outReady = txAdvance && (txState == TX_DATA);

   always_comb begin
      next_txState = txState;
      next_rdCount = rdCount + BW'(rdIf.inValid && rdIf.inReady);
      next_txSent  = txSent;
      next_txWord  = tx_packet_word;
      next_txValid = tx_word_valid;
      next_txFirst = tx_first_word;
      next_txLast  = tx_last_word;
      txDone       = 1'b0;
      if (txAdvance) begin
         next_txValid = 1'b0;
         next_txFirst = 1'b0;
         next_txLast  = 1'b0;
         case (txState)
            TX_IDLE: begin
               if (readPending && (rdCount == rdQw) && (rdQw != '0)) begin
                  next_txWord  = {cplH1, cplH0};
                  next_txValid = 1'b1;
                  next_txFirst = 1'b1;
                  next_txState = TX_HDR1;
               end
            end
            TX_HDR1: begin
               next_txWord  = {32'h0000_0000, cplH2};
               next_txValid = 1'b1;
               next_txSent  = '0;
               next_txState = TX_DATA;
            end
            TX_DATA: begin
               if (rdIf.outValid) begin
                  next_txWord  = rdIf.outData;
                  next_txValid = 1'b1;
                  next_txSent  = txSent + BW'(1);
                  if (txSent == rdQw - BW'(1)) begin
                     next_txLast  = 1'b1;
                     next_txState = TX_IDLE;
                     next_rdCount = '0;
                     txDone       = 1'b1;
                  end
               end
            end
            default: next_txState = TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         txState        <= TX_IDLE;
         rdCount        <= '0;
         txSent         <= '0;
         tx_packet_word <= '0;
         tx_word_valid  <= 1'b0;
         tx_first_word  <= 1'b0;
         tx_last_word   <= 1'b0;
      end else begin
         txState        <= next_txState;
         rdCount        <= next_rdCount;
         txSent         <= next_txSent;
         tx_packet_word <= next_txWord;
         tx_word_valid  <= next_txValid;
         tx_first_word  <= next_txFirst;
         tx_last_word   <= next_txLast;
      end
   end
endmodule

/* bridge_pkg.sv */
// shared constants of the stream-to-sdram bridge
package bridge_pkg;
   // ==========================================
   // widths
   localparam int STREAM_W   = 64;
   localparam int MASK_W     = 8;
   localparam int MEM_DATA_W = 128;
   localparam int MEM_MASK_W = 16;
   localparam int MEM_ADDR_W = 25;
   localparam int BURST_W    = 4;
   localparam int FIFO_DEPTH = 8;
   localparam int CREDIT_W   = 36;
   localparam int CSR_W      = 32;
   localparam int BUSDEV_W   = 13;
   localparam int LEN_W      = 10;
   // ==========================================
   // packet header fields
   localparam int FMT_DATA_BIT = 30;
   localparam int FMT_4DW_BIT  = 29;
   localparam int TYPE_LSB     = 24;
   localparam int REQID_LSB    = 48;
   localparam int TAG_LSB      = 40;
   localparam int LBE_LSB      = 36;
   localparam int FBE_LSB      = 32;
   localparam int ADDR_QW_LSB  = 3;
   localparam logic [4:0] TYPE_MEM   = 5'h0_0;
   localparam logic [7:0] CPLD_BYTE0 = 8'h4A;
   localparam logic [2:0] FUNC_NUM   = 3'h0;
   // ==========================================
   // configuration input fields
   localparam int MRRS_LSB     = 12;
   localparam int MRRS_MIN_QW  = 16;
endpackage

/* stream_if.sv */
// valid/ready carrier between the bridge and its fifos
`timescale 1ns/10ps
interface stream_if #(
   parameter int W = 72
);
   logic         inValid;
   logic         inReady;
   logic [W-1:0] inData;
   logic         outValid;
   logic         outReady;
   logic [W-1:0] outData;
   modport fifo_side (input inValid, input inData, input outReady,
                      output inReady, output outValid, output outData);
   modport user_side (output inValid, output inData, output outReady,
                      input inReady, input outValid, input outData);
endinterface

/* word_fifo.sv */
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module word_fifo #(
   parameter int W     = 72,
   parameter int DEPTH = 8
) (
   input  wire logic clk_sys,
   input  wire logic srst,
   stream_if.fifo_side port
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [PW:0]   count, next_count;
   logic          doPush, doPop;

   // ==========================================
   // handshakes
   assign port.inReady  = (count != (PW+1)'(DEPTH));
   assign port.outValid = (count != '0);
   assign port.outData  = mem[rdPtr];
   assign doPush = port.inValid & port.inReady;
   assign doPop  = port.outValid & port.outReady;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_comb begin
      next_wrPtr = doPush ? bump(wrPtr) : wrPtr;
      next_rdPtr = doPop ? bump(rdPtr) : rdPtr;
      next_count = count + (PW+1)'(doPush) - (PW+1)'(doPop);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (doPush) begin
         mem[wrPtr] <= port.inData;
      end
   end
endmodule

/* bridge_monitor.sv */
// port checks for the stream-to-sdram bridge
`timescale 1ns/10ps
module bridge_monitor (
   input wire logic         clk_sys,
   input wire logic         srst,
   input wire logic [63:0]  tx_packet_word,
   input wire logic         tx_word_valid,
   input wire logic         tx_first_word,
   input wire logic         tx_last_word,
   input wire logic         tx_core_accepting,
   input wire logic         rx_nonposted_hold,
   input wire logic         mem_ready,
   input wire logic [24:0]  mem_address,
   input wire logic         mem_write_req,
   input wire logic         mem_read_req,
   input wire logic [127:0] mem_wdata,
   input wire logic [15:0]  mem_byte_mask,
   input wire logic [3:0]   mem_burst_count
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ==========================================
   // transmit framing
   a_tx_stall_hold: assert property (tx_word_valid && !tx_core_accepting |=> tx_word_valid &&
      $stable(tx_packet_word) && $stable(tx_first_word) && $stable(tx_last_word)) else $error("tx word moved in stall");
   a_first_has_valid: assert property (tx_first_word |-> tx_word_valid) else $error("first flag without valid");
   a_last_has_valid: assert property (tx_last_word |-> tx_word_valid) else $error("last flag without valid");
   a_first_one_beat: assert property (tx_first_word && tx_core_accepting |=> !tx_first_word)
      else $error("first flag longer than one word");
   // ==========================================
   // memory requests
   a_wr_req_hold: assert property (mem_write_req && !mem_ready |=> mem_write_req &&
      $stable(mem_address) && $stable(mem_burst_count)) else $error("write request not held");
   a_rd_req_hold: assert property (mem_read_req && !mem_ready |=> mem_read_req &&
      $stable(mem_address) && $stable(mem_burst_count)) else $error("read request not held");
   a_req_release: assert property ((mem_write_req || mem_read_req) && mem_ready |=>
      !mem_write_req && !mem_read_req) else $error("request stays after accept");
   a_req_exclusive: assert property (!(mem_write_req && mem_read_req)) else $error("read and write together");
   a_wdata_upper: assert property (mem_wdata[127:64] == '0 && mem_byte_mask[15:8] == '0)
      else $error("upper write half used");
   a_nonposted_mask: assert property (mem_read_req |-> rx_nonposted_hold) else $error("reads not masked");
   a_burst_range: assert property ((mem_write_req || mem_read_req) |-> mem_burst_count inside {[1:8]})
      else $error("burst count out of range");
endmodule
bind pcie_stream_to_sdram_bridge bridge_monitor mon_u (.clk_sys, .srst, .tx_packet_word, .tx_word_valid,
   .tx_first_word, .tx_last_word, .tx_core_accepting, .rx_nonposted_hold, .mem_ready, .mem_address,
   .mem_write_req, .mem_read_req, .mem_wdata, .mem_byte_mask, .mem_burst_count);

/* sdram_partner.sv */
// sdram controller model on the bridge's memory port
`timescale 1ns/10ps
module sdram_partner (
   input  wire logic         clk_sys,
   input  wire logic         srst,
   input  wire logic         slow,
   input  wire logic [24:0]  mem_address,
   input  wire logic         mem_write_req,
   input  wire logic         mem_read_req,
   input  wire logic [127:0] mem_wdata,
   input  wire logic [15:0]  mem_byte_mask,
   input  wire logic [3:0]   mem_burst_count,
   output logic              mem_ready,
   output logic              mem_wdata_req,
   output logic [63:0]       mem_rdata,
   output logic              mem_rdata_valid
);
   logic [63:0] mem [0:31];
   logic [15:0] maskSeen;
   logic [4:0]  wAddr, rAddr;
   logic [3:0]  wLeft, rLeft;
   logic [1:0]  rWait;
   logic        wTake, phase;
   // ==========================================
   // request, write and read paths
   assign mem_ready = !slow || phase;
   always_ff @(posedge clk_sys) begin
      phase <= ~phase;
      wTake <= mem_wdata_req;
      mem_rdata_valid <= 1'b0;
      mem_rdata <= ~mem_rdata; // idle bus keeps toggling
      if (srst) begin
         {phase, wTake, wLeft, rLeft, rWait, mem_wdata_req} <= '0;
         mem_rdata <= '0;
      end else begin
         if (mem_write_req && mem_ready)
            {wLeft, wAddr} <= {mem_burst_count, mem_address[4:0]};
         if (mem_read_req && mem_ready)
            {rLeft, rAddr, rWait} <= {mem_burst_count, mem_address[4:0], 2'h3};
         mem_wdata_req <= (wLeft != 4'h0);
         if (wLeft != 4'h0)
            wLeft <= wLeft - 4'h1;
         if (wTake) begin
            mem[wAddr] <= mem_wdata[63:0];
            {maskSeen, wAddr} <= {mem_byte_mask, wAddr + 5'h01};
         end
         if (rWait != 2'h0)
            rWait <= rWait - 2'h1;
         else if (rLeft != 4'h0) begin
            {mem_rdata_valid, mem_rdata} <= {1'b1, mem[rAddr]};
            {rAddr, rLeft} <= {rAddr + 5'h01, rLeft - 4'h1};
         end
      end
   end
endmodule

/* pcie_stream_to_sdram_bridge_tb.sv */
// self-checking bench for the stream-to-sdram bridge
`timescale 1ns/10ps
module pcie_stream_to_sdram_bridge_tb;
   logic         clk_sys = 0, srst = 1, slow = 0, tx_core_accepting = 1;
   logic         rx_data_valid = 0, rx_first_word = 0, rx_last_word = 0;
   logic [63:0]  rx_packet_data = '0, tx_packet_word, mem_rdata;
   logic         rx_app_accepting, rx_nonposted_hold, tx_word_valid, tx_first_word, tx_last_word;
   logic         mem_ready, mem_write_req, mem_read_req, mem_wdata_req, mem_rdata_valid;
   logic [24:0]  mem_address;
   logic [127:0] mem_wdata;
   logic [15:0]  mem_byte_mask;
   logic [3:0]   mem_burst_count;
   logic [12:0]  bus_device_number_in = 13'h0A5B;
   logic [63:0]  d0 = 64'h1122_3344_5566_7788, d1 = 64'h99AA_BBCC_DDEE_F011;
   int           err_total = 0, check_count = 0;
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   pcie_stream_to_sdram_bridge dut_u (.clk_sys, .srst, .rx_packet_data, .rx_data_valid, .rx_first_word,
      .rx_last_word, .rx_app_accepting, .rx_nonposted_hold, .tx_packet_word, .tx_word_valid, .tx_first_word,
      .tx_last_word, .tx_core_accepting, .tx_credit_vector('0), .device_ctrl_status_in('0),
      .bus_device_number_in, .mem_ready, .mem_address, .mem_write_req, .mem_read_req, .mem_wdata_req,
      .mem_wdata, .mem_byte_mask, .mem_burst_count, .mem_rdata, .mem_rdata_valid);
   sdram_partner part_u (.clk_sys, .srst, .slow, .mem_address, .mem_write_req, .mem_read_req, .mem_wdata,
      .mem_byte_mask, .mem_burst_count, .mem_ready, .mem_wdata_req, .mem_rdata, .mem_rdata_valid);
   // ==========================================
   // shared tasks
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic send_pkt(input logic [63:0] w[$]);
      int n;
      foreach (w[i]) begin
         rx_packet_data = w[i];
         rx_first_word = (i == 0);
         rx_last_word = (i == w.size() - 1);
         rx_data_valid = 1;
         n = 0;
         do begin @(posedge clk_sys); n++; end while (rx_app_accepting !== 1'b1 && n < 100);
         if (n >= 100) begin err_total++; print_verdict(); end
         #1;
      end
      {rx_data_valid, rx_first_word, rx_last_word} = 3'h0;
      rx_packet_data = ~rx_packet_data;
   endtask
   task automatic wait_req(input logic rd);
      int n = 0;
      while ((rd ? mem_read_req : mem_write_req) !== 1'b1 && n < 50) begin @(posedge clk_sys); n++; #1; end
      if (n >= 50) begin err_total++; print_verdict(); end
   endtask
   // ==========================================
   // scenarios
   task automatic sc_reset;
      check({tx_word_valid, mem_write_req, mem_read_req, rx_nonposted_hold, rx_app_accepting}, 5'h00);
      srst = 0;
      @(posedge clk_sys);
      #1;
      check(rx_app_accepting, 1'b1);
   endtask
   task automatic sc_write;
      slow = 1;
      send_pkt('{{16'h1234, 8'h01, 8'hFF, 32'h4000_0004}, {32'h0000_0000, 32'h0000_0040}, d0, d1});
      wait_req(0);
      check(mem_address, 25'h000_0008);
      check(mem_burst_count, 4'h2);
      for (int n = 0; n < 60 && part_u.wAddr !== 5'h0A; n++) @(posedge clk_sys);
      if (part_u.wAddr !== 5'h0A) begin err_total++; print_verdict(); end
      #1;
      check(part_u.mem[8], d0);
      check(part_u.mem[9], d1);
      check(part_u.maskSeen, 16'h00FF);
      slow = 0;
   endtask
   task automatic sc_read;
      logic [63:0] got[4];
      logic [3:0]  fst, lst;
      int          k, n;
      {k, fst, lst} = '0;
      send_pkt('{{16'h1234, 8'h05, 8'hFF, 32'h0000_0004}, {32'h0000_0000, 32'h0000_0040}});
      wait_req(1);
      check(mem_address, 25'h000_0008);
      check(rx_nonposted_hold, 1'b1);
      tx_core_accepting = 0;
      send_pkt('{{16'h1234, 8'h06, 8'hFF, 32'h0000_0004}, {32'h0000_0000, 32'h0000_0040}});
      check(mem_read_req, 1'b0);
      for (n = 0; n < 200 && k < 4; n++) begin
         @(posedge clk_sys);
         if (tx_word_valid === 1'b1 && tx_core_accepting) begin
            {got[k], fst[k], lst[k]} = {tx_packet_word, tx_first_word, tx_last_word};
            k++;
         end
         #1;
         tx_core_accepting = n[0];
      end
      if (k < 4) begin err_total++; print_verdict(); end
      check(got[0], {bus_device_number_in, 3'h0, 4'h0, 12'h010, 32'h4A00_0004});
      check(got[1], {32'h0000_0000, 16'h1234, 8'h05, 8'h40});
      check(got[2], d0);
      check(got[3], d1);
      check(fst, 4'h1);
      check(lst, 4'h8);
      @(posedge clk_sys);
      #1;
      tx_core_accepting = 1;
      check(rx_nonposted_hold, 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      #1;
      sc_reset();
      sc_write();
      sc_read();
      print_verdict();
   end
endmodule
